/* logic/acx_pkg.sv */
// Purpose: Shared constants and types for the compressor signal exchange block
// Assumes: 50 MHz system clock, one synchronous active-low reset
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite slave
package acx_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 50_000;
  localparam int unsigned SHIFT_HOLD_MS = 2_500;                  // Longest shift postponement
  localparam int unsigned SHIFT_HOLD_CYC = CLK_KHZ * SHIFT_HOLD_MS; // Exact, no rounding

  // ------------------------------------------------------------
  // Signal encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DIS_IMM = 2'h0,
    MODE_DIS = 2'h1,
    MODE_ENG = 2'h2,
    MODE_RSV = 2'h3
  } acx_mode_t;

  localparam logic AVAIL_NO = 1'b0;
  localparam logic LOAD_VALID = 1'b0;
  localparam logic [7:0] LOAD_DEFAULT = 8'h00;
  localparam logic [7:0] GRAD_NONE = 8'h00;   // Fixed gradient without variable displacement
  localparam logic [7:0] GRAD_SHED = 8'hff;   // Shed load as fast as possible

  // Received frame, one field per network signal
  typedef struct packed {
    logic avail;
    logic failed_on;
    acx_mode_t mode;
    logic load_invalid;
    logic [7:0] load;
  } acx_frame_t;

  // Normalized load handed to the torque calculation
  typedef struct packed {
    logic invalid;
    logic [7:0] load;
  } acx_load_t;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_GRAD = 5'h04;
  localparam logic [ADDR_W-1:0] REG_GMIN = 5'h08;
  localparam logic [ADDR_W-1:0] REG_STAT = 5'h0c;
  localparam int unsigned CTRL_EVD_BIT = 0;
  localparam int unsigned STAT_COMP_BIT = 0;
  localparam int unsigned STAT_FAIL_BIT = 1;
  localparam int unsigned STAT_SUB_BIT = 2;
  localparam int unsigned STAT_INV_BIT = 3;
  localparam int unsigned STAT_MODE_LSB = 4;
  localparam int unsigned STAT_LOAD_LSB = 8;
  localparam int unsigned STAT_GRAD_LSB = 16;
  localparam logic CTRL_EVD_RST = 1'b0;
  localparam logic [7:0] GRAD_RST = 8'h00;
  localparam logic [7:0] GMIN_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* logic/acx_hold.sv */
// Purpose: Holds one received signal between frames, with a failure default
// Assumes: Same clock as the frame source
// Notes:   Substitution has priority over a frame arriving in the same cycle
`timescale 1ns/100ps
module acx_hold #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [W-1:0] d,
  input wire logic sub,
  input wire logic [W-1:0] sub_val,
  output logic [W-1:0] q
);

  logic [W-1:0] next_q;

  // Failure default wins, else a new frame, else keep
  always_comb begin
    next_q = q;
    if (sub) begin
      next_q = sub_val;
    end else if (load) begin
      next_q = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

endmodule

/* logic/acx_timer.sv */
// Purpose: Bounded-duration timer, counts while run is high
// Assumes: CYC is at least one
// Notes:   Count restarts whenever run drops
`timescale 1ns/100ps
module acx_timer #(
  parameter int unsigned CYC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic expired
);

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // Saturating count so expired stays up until run drops
  always_comb begin
    next_cnt = '0;
    if (run) begin
      next_cnt = (cnt == LAST) ? cnt : cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired = run && (cnt == LAST);

endmodule

/* logic/acx_engine_side.sv */
// Purpose: Engine controller end of the compressor signal exchange
// Assumes: Frames and failure flags come from logic on aclk
// Notes:   Normal and minimum gradient values are supplied by software over AXI4-Lite
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

// Function
// RULE1: Failed-on flag switches compressor control off
// RULE2: Failed-on defaults false on failure or unavailable
// RULE3: Gateway sends false without variable displacement
// RULE4: Gateway sets failed-on only with fault code
// RULE5: Gateway starts and idles failed-on false
// RULE6: Gateway supervises failed-on source by availability
// RULE7: Mode is two bits, three is unassigned
// RULE8: No air conditioning means disengage immediately
// RULE9: Disengage immediately without load management, quickly
// RULE10: Disengage may wait for shift, bounded
// RULE11: Mode defaults disengage immediately, also on failure
// RULE12: Eight-bit load feeds torque calculation
// RULE13: Invalid load forces minimum allowed gradient
// RULE14: Load defaults zero, valid on failure
// RULE15: Gateway marks load invalid only on failure
// RULE16: Gateway starts with load zero, valid
// RULE17: Gradient always sent, zero without variable displacement
// RULE18: Gradient is maximum load change rate
// RULE19: Availability bit, zero means source unavailable
// RULE20: Last received values held between frames
module acx_engine_side #(
  parameter int unsigned SHIFT_HOLD_CYC = acx_pkg::SHIFT_HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire acx_pkg::acx_frame_t rx_frame,
  input wire logic serial_fail,
  input wire logic hardwire_fail,
  input wire logic shift_active,
  output logic comp_ctrl,
  output acx_pkg::acx_load_t torque_load,
  output logic [7:0] gradient_tx,
  input wire logic [acx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import acx_pkg::*;

  // ------------------------------------------------------------
  // Received signal holding and substitution
  // ------------------------------------------------------------
  logic avail_q;
  logic failed_q;
  acx_mode_t mode_q;
  logic [1:0] mode_raw;
  logic src_down;
  logic mode_down;

  // Source is down on link failure or when the newest availability says so
  assign src_down = serial_fail || (rx_valid ? (rx_frame.avail == AVAIL_NO) : (avail_q == AVAIL_NO)); // RULE19
  assign mode_down = src_down || hardwire_fail; // RULE11
  assign mode_q = acx_mode_t'(mode_raw);

  // Availability resets to unavailable, so all defaults apply at power-up
  acx_hold #(.W(1), .RST(AVAIL_NO)) u_hold_avail (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rx_valid),
    .d(rx_frame.avail),
    .sub(1'b0),
    .sub_val(AVAIL_NO),
    .q(avail_q)
  );

  acx_hold #(.W(1), .RST(1'b0)) u_hold_fail (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rx_valid), // RULE20
    .d(rx_frame.failed_on),
    .sub(src_down), // RULE2
    .sub_val(1'b0),
    .q(failed_q)
  );

  acx_hold #(.W(2), .RST(MODE_DIS_IMM)) u_hold_mode (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rx_valid), // RULE20
    .d(rx_frame.mode),
    .sub(mode_down), // RULE11
    .sub_val(MODE_DIS_IMM),
    .q(mode_raw)
  );

  // Held load goes straight to the torque calculation
  acx_hold #(.W(9), .RST({LOAD_VALID, LOAD_DEFAULT})) u_hold_load (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rx_valid), // RULE20
    .d({rx_frame.load_invalid, rx_frame.load}), // RULE12
    .sub(src_down), // RULE14
    .sub_val({LOAD_VALID, LOAD_DEFAULT}),
    .q(torque_load)
  );

  // ------------------------------------------------------------
  // Compressor control state machine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_POST} acx_state_t;
  acx_state_t state;
  acx_state_t next_state;
  logic next_comp_ctrl;
  logic post_expired;

  acx_timer #(.CYC(SHIFT_HOLD_CYC)) u_post_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state == ST_POST),
    .expired(post_expired)
  );

  // Unassigned mode is treated as the safe disengage-immediately case for comp_ctrl; the gradient is not shed
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (mode_q == MODE_ENG && !failed_q) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (failed_q || mode_q == MODE_DIS_IMM || mode_q == MODE_RSV) begin // RULE1 RULE9 RULE7
          next_state = ST_OFF;
        end else if (mode_q == MODE_DIS) begin
          next_state = shift_active ? ST_POST : ST_OFF; // RULE10
        end
      end
      ST_POST: begin
        if (failed_q || mode_q == MODE_DIS_IMM || mode_q == MODE_RSV) begin // RULE1 RULE9
          next_state = ST_OFF;
        end else if (mode_q == MODE_ENG) begin
          next_state = ST_ON;
        end else if (!shift_active || post_expired) begin // RULE10
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    next_comp_ctrl = (next_state != ST_OFF);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
      comp_ctrl <= 1'b0;
    end else begin
      state <= next_state;
      comp_ctrl <= next_comp_ctrl;
    end
  end

  // ------------------------------------------------------------
  // Control registers and gradient output
  // ------------------------------------------------------------
  logic evd_present;
  logic [7:0] grad_norm;
  logic [7:0] grad_min;
  logic next_evd_present;
  logic [7:0] next_grad_norm;
  logic [7:0] next_grad_min;
  logic [7:0] next_gradient_tx;
  logic wr_fire;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // All writable fields sit in byte lane 0, so only that strobe matters
  always_comb begin
    next_evd_present = evd_present;
    next_grad_norm = grad_norm;
    next_grad_min = grad_min;
    if (wr_fire && w_strb[0]) begin
      case (aw_addr)
        REG_CTRL: next_evd_present = w_data[CTRL_EVD_BIT];
        REG_GRAD: next_grad_norm = w_data[7:0];
        REG_GMIN: next_grad_min = w_data[7:0];
        default: next_evd_present = evd_present;
      endcase
    end
    // Gradient priority: no variable displacement, invalid load, urgent shed
    if (!evd_present) begin
      next_gradient_tx = GRAD_NONE; // RULE17
    end else if (torque_load.invalid != LOAD_VALID) begin
      next_gradient_tx = grad_min; // RULE13
    end else if (mode_q == MODE_DIS_IMM) begin
      next_gradient_tx = GRAD_SHED; // RULE18
    end else begin
      next_gradient_tx = grad_norm; // RULE18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evd_present <= CTRL_EVD_RST;
      grad_norm <= GRAD_RST;
      grad_min <= GMIN_RST;
      gradient_tx <= GRAD_NONE;
    end else begin
      evd_present <= next_evd_present;
      grad_norm <= next_grad_norm;
      grad_min <= next_grad_min;
      gradient_tx <= next_gradient_tx;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic next_aw_got;
  logic next_w_got;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  // Address and data latch in any order; the write lands once both are in
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == REG_CTRL || aw_addr == REG_GRAD || aw_addr == REG_GMIN) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic [ADDR_W-1:0] ar_addr;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  // Status shows the held, substituted signals the engine side acts on
  always_comb begin
    stat_word = '0;
    stat_word[STAT_COMP_BIT] = comp_ctrl;
    stat_word[STAT_FAIL_BIT] = failed_q;
    stat_word[STAT_SUB_BIT] = src_down;
    stat_word[STAT_INV_BIT] = torque_load.invalid;
    stat_word[STAT_MODE_LSB +: 2] = mode_raw;
    stat_word[STAT_LOAD_LSB +: 8] = torque_load.load;
    stat_word[STAT_GRAD_LSB +: 8] = gradient_tx;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (ar_addr)
        REG_CTRL: next_rdata = {31'h0, evd_present};
        REG_GRAD: next_rdata = {24'h0, grad_norm};
        REG_GMIN: next_rdata = {24'h0, grad_min};
        REG_STAT: next_rdata = stat_word;
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles the compressor has stayed on under a plain disengage request
  logic [31:0] dis_on_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dis_on_cnt <= '0;
    end else begin
      dis_on_cnt <= (comp_ctrl && mode_q == MODE_DIS) ? dis_on_cnt + 1'b1 : '0;
    end
  end

  property p_fail_off;
    failed_q |-> ##[1:2] !comp_ctrl;
  endproperty
  a_fail_off: assert property (p_fail_off) else $error("Failed-on flag did not drop compressor"); // RULE1

  property p_fail_default;
    src_down |=> !failed_q;
  endproperty
  a_fail_default: assert property (p_fail_default) else $error("Failed-on not defaulted false"); // RULE2

  property p_rsv_off;
    (mode_q == MODE_RSV) [*2] |-> !comp_ctrl;
  endproperty
  a_rsv_off: assert property (p_rsv_off) else $error("Unassigned mode left compressor on"); // RULE7

  property p_imm_off;
    (mode_q == MODE_DIS_IMM) ##1 (mode_q == MODE_DIS_IMM) |-> !comp_ctrl;
  endproperty
  a_imm_off: assert property (p_imm_off) else $error("Immediate disengage was delayed"); // RULE9

  property p_post_bound;
    dis_on_cnt <= SHIFT_HOLD_CYC + 2;
  endproperty
  a_post_bound: assert property (p_post_bound) else $error("Shift postponement too long"); // RULE10

  property p_post_shift;
    (state == ST_POST) && !shift_active && mode_q == MODE_DIS |=> !comp_ctrl;
  endproperty
  a_post_shift: assert property (p_post_shift) else $error("Postponed without a shift"); // RULE10

  property p_mode_default;
    mode_down |=> mode_q == MODE_DIS_IMM;
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("Mode not defaulted on failure"); // RULE11

  property p_load_default;
    src_down |=> torque_load == {LOAD_VALID, LOAD_DEFAULT};
  endproperty
  a_load_default: assert property (p_load_default) else $error("Load not defaulted on failure"); // RULE14

  property p_load_take;
    rx_valid && !src_down |=> torque_load.invalid == $past(rx_frame.load_invalid)
      && torque_load.load == $past(rx_frame.load);
  endproperty
  a_load_take: assert property (p_load_take) else $error("Received load not taken"); // RULE12

  property p_grad_min;
    evd_present && torque_load.invalid |=> gradient_tx == $past(grad_min);
  endproperty
  a_grad_min: assert property (p_grad_min) else $error("Invalid load without minimum gradient"); // RULE13

  property p_grad_none;
    !evd_present |=> gradient_tx == GRAD_NONE;
  endproperty
  a_grad_none: assert property (p_grad_none) else $error("Gradient not zero without displacement control"); // RULE17

  property p_grad_shed;
    evd_present && !torque_load.invalid && mode_q == MODE_DIS_IMM |=> gradient_tx == GRAD_SHED;
  endproperty
  a_grad_shed: assert property (p_grad_shed) else $error("No fast shed gradient"); // RULE18

  property p_hold;
    !rx_valid && !mode_down |=> $stable(torque_load) && $stable(mode_raw) && $stable(failed_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Held value changed without frame"); // RULE20

  c_engage: cover property (mode_q == MODE_ENG ##1 comp_ctrl);
  c_postpone: cover property (state == ST_POST ##1 state == ST_OFF);
  c_substitute: cover property (serial_fail ##1 torque_load == {LOAD_VALID, LOAD_DEFAULT});
  c_grad_min: cover property (evd_present && torque_load.invalid ##1 gradient_tx == grad_min);

endmodule

/* tb/acx_gw_model.sv */
// Purpose: Gateway stand-in that relays climate frames to the engine side
// Assumes: One-cycle send strobe from the bench per frame
// Notes: Between frames the frame lines toggle so stale data is never trusted
`timescale 1ns/100ps
module acx_gw_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic send,
  input wire acx_pkg::acx_frame_t frame_in,
  output logic rx_valid,
  output acx_pkg::acx_frame_t rx_frame
);
  import acx_pkg::*;
  // --------------------
  // Frame launcher
  // --------------------
  localparam acx_frame_t PWR_UP = '{AVAIL_NO, 1'b0, MODE_DIS_IMM, LOAD_VALID, LOAD_DEFAULT};
  logic next_rx_valid;
  acx_frame_t next_rx_frame;
  // Outside a frame show the inverse, a receiver that ignores rx_valid sees junk
  always_comb begin
    next_rx_valid = send;
    next_rx_frame = send ? frame_in : ~rx_frame;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_frame <= PWR_UP;
    end else begin
      rx_valid <= next_rx_valid;
      rx_frame <= next_rx_frame;
    end
  end
endmodule

/* tb/acx_engine_side_tb_top.sv */
// Purpose: Self-checking bench for the engine side of the compressor exchange
// Assumes: Shift hold shortened to 20 cycles
// Notes: Register traffic over AXI4-Lite, frames through the gateway model
`timescale 1ns/100ps
module acx_engine_side_tb_top;
  import acx_pkg::*;
  logic aclk, aresetn, send, serial_fail, hardwire_fail, shift_active, comp_ctrl, rx_valid;
  acx_frame_t frame_in, rx_frame;
  acx_load_t torque_load;
  logic [7:0] gradient_tx;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int num_errors, check_count;

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  acx_gw_model u_acx_gw_model (.aclk(aclk), .aresetn(aresetn), .send(send), .frame_in(frame_in),
    .rx_valid(rx_valid), .rx_frame(rx_frame));

  acx_engine_side #(.SHIFT_HOLD_CYC(20)) u_acx_engine_side (.aclk(aclk), .aresetn(aresetn),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .serial_fail(serial_fail), .hardwire_fail(hardwire_fail),
    .shift_active(shift_active), .comp_ctrl(comp_ctrl), .torque_load(torque_load), .gradient_tx(gradient_tx),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // --------------------
  // Tasks
  // --------------------
  task print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data go out together, each dropped once its own ready is seen
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task rdr(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // One whole frame, then enough edges for hold, control and gradient to settle
  task fr(input logic av, input logic fo, input acx_mode_t m, input logic inv, input logic [7:0] ld);
    @(posedge aclk);
    frame_in <= '{av, fo, m, inv, ld};
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask

  // Hang guard, the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    print_verdict;
  end

  initial begin
    {aresetn, send, serial_fail, hardwire_fail, shift_active} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    frame_in = '0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(comp_ctrl, 32'h0);
    chk(torque_load, 32'h0);
    chk(gradient_tx, GRAD_NONE);
    for (int i = 0; i < 3; i++) begin
      rdr(5'(i * 4));
      chk(rd, 32'h0);
      chk(rsp, RESP_OKAY);
    end
    rdr(5'h10);
    chk(rsp, RESP_SLVERR);
    wr(5'h14, 32'hff);
    chk(rsp, RESP_SLVERR);
    wr(REG_CTRL, 32'h1);
    wr(REG_GRAD, 32'h40);
    wr(REG_GMIN, 32'h05);
    rdr(REG_GRAD);
    chk(rd, 32'h40);
    // Engage with a valid load, then hold it across a quiet stretch
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h7b);
    chk(comp_ctrl, 32'h1);
    chk(torque_load, 32'h07b);
    chk(gradient_tx, 8'h40);
    repeat (30) @(posedge aclk);
    chk(torque_load, 32'h07b);
    fr(1'b1, 1'b0, MODE_ENG, 1'b1, 8'h33);
    chk(torque_load, 32'h133);
    chk(gradient_tx, 8'h05);
    fr(1'b1, 1'b0, MODE_DIS_IMM, 1'b0, 8'h10);
    chk(comp_ctrl, 32'h0);
    chk(gradient_tx, GRAD_SHED);
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h20);
    fr(1'b1, 1'b0, MODE_RSV, 1'b0, 8'h20);
    chk(comp_ctrl, 32'h0);
    // Disengage during a shift: held, but only for the bounded time
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h20);
    shift_active <= 1'b1;
    fr(1'b1, 1'b0, MODE_DIS, 1'b0, 8'h20);
    chk(comp_ctrl, 32'h1);
    repeat (22) @(posedge aclk);
    chk(comp_ctrl, 32'h0);
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h20);
    fr(1'b1, 1'b0, MODE_DIS, 1'b0, 8'h20);
    shift_active <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(comp_ctrl, 32'h0);
    fr(1'b1, 1'b1, MODE_ENG, 1'b0, 8'h20);
    chk(comp_ctrl, 32'h0);
    rdr(REG_STAT);
    chk(rd[STAT_FAIL_BIT], 32'h1);
    // Serial failure replaces held failed-on, mode and load with their defaults
    serial_fail <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(torque_load, 32'h0);
    rdr(REG_STAT);
    chk(rd[STAT_FAIL_BIT], 32'h0);
    chk(rd[STAT_MODE_LSB +: 2], MODE_DIS_IMM);
    serial_fail <= 1'b0;
    fr(1'b0, 1'b1, MODE_ENG, 1'b1, 8'h55);
    chk(torque_load, 32'h0);
    chk(comp_ctrl, 32'h0);
    rdr(REG_STAT);
    chk(rd[STAT_FAIL_BIT], 32'h0);
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h20);
    chk(comp_ctrl, 32'h1);
    hardwire_fail <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(comp_ctrl, 32'h0);
    hardwire_fail <= 1'b0;
    // Without variable displacement the gradient goes out as zero
    wr(REG_CTRL, 32'h0);
    fr(1'b1, 1'b0, MODE_ENG, 1'b0, 8'h20);
    chk(gradient_tx, GRAD_NONE);
    print_verdict;
  end
endmodule
